// file: hdl/sbts_slave.sv
// smbus slave for block write, receive byte and block read with pec
// assumes scl/sda are open-drain pins resolved outside; addr is static
//
// Overview of operation
// - block write: address with write bit, command 0xfc, then count
// - device acks command, count and every data byte; master stops
// - eeprom byte programs in about 250 us; scl held low before the ack of a byte written meanwhile
// - receive byte returns one byte from the set location
// - block read returns count 0x20 then exactly 32 data bytes
// - optional check byte follows last data byte of write or read
// - check byte is crc-8 with polynomial x^8+x^2+x+1
// - ram spans 0x00..0xdf, eeprom spans 0xf800..0xfbff
// - during page erase of about 20 ms every access is nacked
`timescale 1ns/10ps
`include "sbts_map.svh"

module sbts_slave
  import sbts_pkg::*;
#(
  parameter int PROG_CYCLES  = `SBTS_PROG_CYC,
  parameter int ERASE_CYCLES = `SBTS_ERASE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [6:0] slave_addr,
  input  wire logic       erase_enable,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            prog_busy,
  output logic            erase_busy
);

  sbts_regs_t r;
  sbts_regs_t n;
  logic        mem_we;
  logic [10:0] mem_waddr;
  logic [7:0]  mem_wdata;
  logic [10:0] mem_raddr;
  logic [7:0]  mem_rdata;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        ptr_is_ee;
  logic        ptr_is_ram;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] v;
    v = c ^ d;
    for (int i = 0; i < 8; i++) begin
      v = v[7] ? ((v << 1) ^ `SBTS_CRC_POLY) : (v << 1);
    end
    return v;
  endfunction

  function automatic logic [10:0] mem_index(input logic [15:0] p);
    return (p[15:8] >= `SBTS_EE_HI_MIN) ? {1'b1, p[9:0]}
                                         : {3'b000, p[7:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  assign scl_rise   = r.scl_s2 & ~r.scl_d;
  assign scl_fall   = ~r.scl_s2 & r.scl_d;
  assign start_cond = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
  assign stop_cond  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
  assign ptr_is_ee  = (r.ptr[15:8] >= `SBTS_EE_HI_MIN) &&
                      (r.ptr[15:8] <= `SBTS_EE_HI_MAX);
  assign ptr_is_ram = (r.ptr[15:8] == 8'h00) &&
                      (r.ptr[7:0] <= `SBTS_RAM_TOP);
  assign mem_raddr  = mem_index(r.ptr);

  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe     = r.scl_hold;
  assign sda_oe     = r.sda_drv;
  assign prog_busy  = (r.prog_cnt != 22'h0);
  assign erase_busy = (r.erase_cnt != 22'h0);

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       store;
    logic [7:0] tx;
    logic       tx_mem;
    store     = 1'b0;
    tx        = 8'h00;
    tx_mem    = 1'b0;
    n         = r;
    mem_we    = 1'b0;
    mem_waddr = mem_index(r.ptr);
    mem_wdata = r.shreg;

    // two-flop synchronisers; edges compare the second stage with its delayed copy
    n.scl_s1 = scl_in;
    n.scl_s2 = r.scl_s1;
    n.scl_d  = r.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_d  = r.sda_s2;

    if (r.prog_cnt != 22'h0) begin
      n.prog_cnt = r.prog_cnt - 22'h1;
    end
    if (r.erase_cnt != 22'h0) begin
      n.erase_cnt = r.erase_cnt - 22'h1;
      if (r.erase_idx != `SBTS_PAGE_BYTES) begin
        mem_we     = 1'b1;
        mem_waddr  = {1'b1, r.ptr[9:5], r.erase_idx[4:0]};
        mem_wdata  = `SBTS_ERASE_FILL;
        n.erase_idx = r.erase_idx + 6'h1;
      end
    end

    // read byte source for the next transmitted byte
    if (r.rd_mode) begin
      if (r.rcnt == 6'h0) begin
        tx = `SBTS_BLK_LEN;
      end else if (r.rcnt <= `SBTS_BLK_LEN6) begin
        tx     = mem_rdata;
        tx_mem = 1'b1;
      end else begin
        tx = r.crc;
      end
    end else if (r.rcnt == 6'h0) begin
      tx     = mem_rdata;
      tx_mem = 1'b1;
    end else begin
      tx = r.crc;
    end

    case (r.st)
      ST_IDLE: begin
        n.sda_drv  = 1'b0;
        n.scl_hold = 1'b0;
      end
      ST_ADDR, ST_RX: begin
        if (scl_rise) begin
          n.shreg  = {r.shreg[6:0], r.sda_s2};
          n.bitcnt = r.bitcnt + 4'h1;
        end
        if (scl_fall && r.bitcnt == 4'h8) begin
          n.crc = crc8(r.crc, r.shreg);
          if (r.st == ST_ADDR) begin
            // erase in progress: stay silent, master sees a nack
            if (r.shreg[7:1] == slave_addr && !erase_busy) begin
              n.sda_drv = 1'b1;
              n.is_rd   = r.shreg[0];
              n.rcnt    = 6'h0;
              n.wcnt    = 6'h0;
              n.rd_mode = r.have_cmd && (r.cmd == `SBTS_CMD_BLK_RD);
              n.st      = ST_ACK;
            end else begin
              n.st = ST_IDLE;
            end
          end else begin
            // ack goes out under the stretch, so sda never moves with scl
            n.sda_drv  = 1'b1;
            n.scl_hold = prog_busy;
            n.st       = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        // stretch until the previous eeprom byte has programmed
        n.scl_hold = prog_busy;
        if (!prog_busy) begin
          n.sda_drv = 1'b1;
          n.st      = ST_ACK;
          n.wcnt    = (r.wcnt == `SBTS_WCNT_MAX) ? r.wcnt : r.wcnt + 6'h1;
          if (r.wcnt == 6'h0) begin
            n.cmd      = r.shreg;
            n.have_cmd = 1'b1;
            if (r.shreg <= `SBTS_RAM_TOP) begin
              n.ptr = {8'h00, r.shreg};
            end else if (r.shreg >= `SBTS_EE_HI_MIN &&
                         r.shreg <= `SBTS_EE_HI_MAX) begin
              n.ptr[15:8] = r.shreg;
            end else if (r.shreg == `SBTS_CMD_ERASE && erase_enable &&
                         ptr_is_ee) begin
              n.erase_cnt = 22'(ERASE_CYCLES);
              n.erase_idx = 6'h0;
            end
          end else if (r.cmd == `SBTS_CMD_BLK_WR) begin
            if (r.wcnt == 6'h1) begin
              n.blk_cnt = r.shreg;
            end else if ({2'b00, r.wcnt - 6'h1} <= r.blk_cnt) begin
              store = 1'b1;
            end
          end else if (r.cmd >= `SBTS_EE_HI_MIN &&
                       r.cmd <= `SBTS_EE_HI_MAX) begin
            if (r.wcnt == 6'h1) begin
              n.ptr[7:0] = r.shreg;
            end else if (r.wcnt == 6'h2) begin
              store = 1'b1;
            end
          end else if (r.cmd <= `SBTS_RAM_TOP && r.wcnt == 6'h1) begin
            store = 1'b1;
          end
          // bytes past the data are the check byte and are not stored
          if (store && (ptr_is_ee || ptr_is_ram)) begin
            mem_we    = 1'b1;
            mem_waddr = mem_index(r.ptr);
            mem_wdata = r.shreg;
            n.ptr     = r.ptr + 16'h1;
            if (ptr_is_ee) begin
              n.prog_cnt = 22'(PROG_CYCLES);
            end
          end
        end
      end
      ST_ACK: begin
        n.scl_hold = 1'b0;
        if (scl_fall) begin
          n.bitcnt = 4'h0;
          if (r.is_rd) begin
            n.shreg   = tx;
            n.sda_drv = ~tx[7];
            // saturate so a long read keeps repeating the check byte
            n.rcnt    = (r.rcnt == `SBTS_WCNT_MAX) ? r.rcnt : r.rcnt + 6'h1;
            if (tx_mem) begin
              n.ptr = r.ptr + 16'h1;
            end
            if (tx_mem || (r.rd_mode && r.rcnt == 6'h0)) begin
              n.crc = crc8(r.crc, tx);
            end
            n.st = ST_TX;
          end else begin
            n.sda_drv = 1'b0;
            n.st      = ST_RX;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (r.bitcnt == `SBTS_LAST_BIT) begin
            n.sda_drv = 1'b0;
            n.st      = ST_MACK;
          end else begin
            n.shreg   = {r.shreg[6:0], 1'b0};
            n.sda_drv = ~r.shreg[6];
            n.bitcnt  = r.bitcnt + 4'h1;
          end
        end
      end
      ST_MACK: begin
        // master ack asks for more, nack ends the read
        if (scl_rise) begin
          n.st = r.sda_s2 ? ST_IDLE : ST_ACK;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // start clears crc only outside a frame, so the repeated start keeps it
    if (start_cond) begin
      n.st       = ST_ADDR;
      n.bitcnt   = 4'h0;
      n.sda_drv  = 1'b0;
      n.scl_hold = 1'b0;
      n.in_frame = 1'b1;
      if (!r.in_frame) begin
        n.crc = `SBTS_CRC_INIT;
      end
    end else if (stop_cond) begin
      n.st       = ST_IDLE;
      n.sda_drv  = 1'b0;
      n.scl_hold = 1'b0;
      n.in_frame = 1'b0;
      n.have_cmd = 1'b0;
      n.rd_mode  = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (reset) begin
      r        <= '0;
      r.st     <= ST_IDLE;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d  <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  sbts_mem u_mem (
    .core_clk (core_clk),
    .wr_en    (mem_we),
    .wr_addr  (mem_waddr),
    .wr_data  (mem_wdata),
    .rd_addr  (mem_raddr),
    .rd_data  (mem_rdata)
  );

endmodule

// file: common/sbts_map.svh
// named constants of the smbus block transfer slave
// assumes a 125 mhz core clock; included by bare name
`ifndef SBTS_MAP_SVH
`define SBTS_MAP_SVH

`define SBTS_CMD_BLK_WR   8'hfc
`define SBTS_CMD_BLK_RD   8'hfd
`define SBTS_CMD_ERASE    8'hfe
`define SBTS_BLK_LEN      8'h20
`define SBTS_BLK_LEN6     6'h20
`define SBTS_RAM_TOP      8'hdf
`define SBTS_EE_HI_MIN    8'hf8
`define SBTS_EE_HI_MAX    8'hfb
`define SBTS_CRC_POLY     8'h07
`define SBTS_CRC_INIT     8'h00
`define SBTS_ERASE_FILL   8'hff
`define SBTS_PAGE_BYTES   6'h20
`define SBTS_LAST_BIT     4'h7
`define SBTS_WCNT_MAX     6'h3f
`define SBTS_CLK_MHZ      125
`define SBTS_PROG_TIME_US 250
`define SBTS_ERASE_TIME_MS 20
`define SBTS_PROG_CYC  (`SBTS_PROG_TIME_US * `SBTS_CLK_MHZ)
`define SBTS_ERASE_CYC (`SBTS_ERASE_TIME_MS * 1000 * `SBTS_CLK_MHZ)

`endif

// file: common/sbts_pkg.sv
// types of the smbus block transfer slave
// assumes sbts_map.svh supplies the numeric constants
package sbts_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_HOLD, ST_ACK, ST_TX, ST_MACK
  } sbts_state_t;

  typedef struct packed {
    sbts_state_t st;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  cmd;
    logic [7:0]  blk_cnt;
    logic [7:0]  crc;
    logic        have_cmd;
    logic        in_frame;
    logic        is_rd;
    logic        rd_mode;
    logic        sda_drv;
    logic        scl_hold;
    logic [5:0]  wcnt;
    logic [5:0]  rcnt;
    logic [15:0] ptr;
    logic [21:0] prog_cnt;
    logic [21:0] erase_cnt;
    logic [5:0]  erase_idx;
  } sbts_regs_t;

endpackage

// file: hdl/sbts_mem.sv
// byte memory holding ram and eeprom space of the slave
// assumes one write port and a registered read port on core_clk
`timescale 1ns/10ps

module sbts_mem (
  input  wire logic        core_clk,
  input  wire logic        wr_en,
  input  wire logic [10:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [10:0] rd_addr,
  output logic      [7:0]  rd_data
);

  logic [7:0] mem [0:2047];

  // no reset: contents are data, not control state
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// file: verif/sbts_monitor.sv
// pin-level assertions for the smbus block transfer slave
// assumes a bind onto sbts_slave with its count parameters
`timescale 1ns/10ps

module sbts_monitor #(
  parameter int PROG_CYCLES  = 600,
  parameter int ERASE_CYCLES = 2000
) (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [6:0] slave_addr,
  input wire logic       erase_enable,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       prog_busy,
  input wire logic       erase_busy
);
  int pcnt;
  int ecnt;

  // busy run lengths, cleared whenever the flag drops
  always_ff @(posedge core_clk) begin
    pcnt <= (prog_busy && !reset) ? pcnt + 1 : 0;
    ecnt <= (erase_busy && !reset) ? ecnt + 1 : 0;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////
  a_pins_open: assert property (
    scl_out == 1'b0 && sda_out == 1'b0) else $error("pin driven high");
  a_sda_scl_low: assert property (
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("sda moved while scl high");
  a_stretch_low: assert property (
    $rose(scl_oe) |-> !$past(scl_in)) else $error("stretch cut high phase");
  a_stretch_busy: assert property (
    scl_oe |-> prog_busy || $past(prog_busy)) else $error("stretch idle");
  a_prog_len: assert property (
    $fell(prog_busy) |-> pcnt >= PROG_CYCLES - 1) else $error("short program");
  a_prog_max: assert property (
    prog_busy |-> pcnt <= PROG_CYCLES + 1) else $error("long program");
  a_erase_len: assert property (
    $fell(erase_busy) |-> ecnt >= ERASE_CYCLES - 1) else $error("short erase");
  a_erase_gate: assert property (
    $rose(erase_busy) |-> erase_enable) else $error("erase not enabled");
endmodule

bind sbts_slave sbts_monitor #(
  .PROG_CYCLES  (PROG_CYCLES),
  .ERASE_CYCLES (ERASE_CYCLES)
) mon_u (.*);

// file: verif/sbts_host.sv
// smbus host model, master side of the slave pins
// assumes the bench resolves both open-drain wires with pull-ups
`timescale 1ns/10ps

module sbts_host (
  input  wire logic       core_clk,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic            res_stb,
  output logic [8:0]      res
);
  int half_len = 16;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    res_stb = 1'b0;
    res = 9'h000;
  end

  task automatic half();
    repeat (half_len) @(negedge core_clk);
  endtask

  // release scl, then honour a stretch by the slave of up to 2000 cycles
  task automatic rise();
    scl_oe = 1'b0;
    for (int n = 0; n < 2000 && scl !== 1'b1; n++) @(negedge core_clk);
    half();
  endtask

  // sda released a half early so no stop is mistaken
  task automatic start();
    sda_oe = 1'b0;
    half();
    rise();
    sda_oe = 1'b1;
    half();
    scl_oe = 1'b1;
    half();
  endtask

  task automatic stop();
    sda_oe = 1'b1;
    half();
    rise();
    sda_oe = 1'b0;
    half();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    half();
    rise();
    r = sda;
    scl_oe = 1'b1;
    half();
  endtask

  task automatic put(input logic [8:0] v);
    res = v;
    res_stb = 1'b1;
    @(negedge core_clk);
    res_stb = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    put({r, 8'h00});
  endtask

  task automatic rd_byte(input logic ack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
    put({1'b0, d});
  endtask
endmodule

// file: verif/sbts_tb.sv
// self-checking bench for the smbus block transfer slave
// assumes sbts_host as bus master and the bound pin monitor
`timescale 1ns/10ps
`include "sbts_map.svh"

module tb;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [6:0] slave_addr = 7'h00;
  logic       erase_enable = 1'b0;
  wire        scl;
  wire        sda;
  logic       scl_oe, sda_oe, m_scl, m_sda, prog_busy, erase_busy, res_stb;
  logic [8:0] res;
  logic [7:0] crc;
  logic [7:0] dat [32];
  logic [8:0] q [$];
  int         fail_count = 0;
  int         tests_run = 0;
  int         cyc = 0;

  always #4 core_clk = ~core_clk;
  assign scl = ~(scl_oe | m_scl);
  assign sda = ~(sda_oe | m_sda);

  sbts_slave #(.PROG_CYCLES(600), .ERASE_CYCLES(2000)) dut_u (
    .core_clk(core_clk), .reset(reset), .slave_addr(slave_addr),
    .erase_enable(erase_enable), .scl_in(scl), .scl_out(),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .prog_busy(prog_busy), .erase_busy(erase_busy));
  sbts_host host_u (.core_clk(core_clk), .scl(scl), .sda(sda),
    .scl_oe(m_scl), .sda_oe(m_sda), .res_stb(res_stb), .res(res));

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] c8(logic [7:0] c, logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // f: expected nack on a write, master ack on a read
  task automatic xb(input logic [7:0] b, input logic f, input logic rd);
    q.push_back(rd ? {1'b0, b} : {f, 8'h00});
    crc = c8(crc, b);
    if (rd) host_u.rd_byte(f);
    else host_u.wr_byte(b);
  endtask

  task automatic st(input logic rd);
    crc = 8'h00;
    host_u.start();
    xb({slave_addr, rd}, 1'b0, 1'b0);
  endtask

  task automatic ptr(input logic [7:0] hi, input logic [7:0] lo, logic ee);
    st(1'b0);
    xb(hi, 1'b0, 1'b0);
    if (ee) xb(lo, 1'b0, 1'b0);
    host_u.stop();
  endtask

  always @(posedge core_clk) begin
    if (res_stb === 1'b1 && q.size() > 0) chk(res, q.pop_front());
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(98859));
    slave_addr = 7'($urandom);
    host_u.half_len = $urandom_range(18, 16);
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    ptr(8'h10, 8'h00, 1'b0);
    st(1'b0);
    xb(`SBTS_CMD_BLK_WR, 1'b0, 1'b0);
    xb(8'd32, 1'b0, 1'b0);
    foreach (dat[i]) begin
      dat[i] = 8'($urandom);
      xb(dat[i], 1'b0, 1'b0);
    end
    host_u.stop();
    ptr(8'h10, 8'h00, 1'b0);
    st(1'b0);
    xb(`SBTS_CMD_BLK_RD, 1'b0, 1'b0);
    host_u.start();
    xb({slave_addr, 1'b1}, 1'b0, 1'b0);
    xb(`SBTS_BLK_LEN, 1'b1, 1'b1);
    foreach (dat[i]) xb(dat[i], 1'b1, 1'b1);
    xb(crc, 1'b0, 1'b1);
    host_u.stop();
    // foreign address must be left alone
    host_u.start();
    xb({slave_addr ^ 7'h01, 1'b0}, 1'b1, 1'b0);
    host_u.stop();
    erase_enable = 1'b1;
    ptr(8'hf8, 8'h05, 1'b1);
    st(1'b0);
    xb(`SBTS_CMD_ERASE, 1'b0, 1'b0);
    host_u.stop();
    host_u.start();
    xb({slave_addr, 1'b0}, 1'b1, 1'b0);
    host_u.stop();
    for (int n = 0; n < 4000 && erase_busy !== 1'b0; n++) @(negedge core_clk);
    ptr(8'hf8, 8'h05, 1'b1);
    st(1'b0);
    xb(`SBTS_CMD_BLK_WR, 1'b0, 1'b0);
    xb(8'd3, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) xb(dat[i], 1'b0, 1'b0);
    host_u.stop();
    ptr(8'hf8, 8'h05, 1'b1);
    for (int i = 0; i < 4; i++) begin
      st(1'b1);
      xb(i < 3 ? dat[i] : `SBTS_ERASE_FILL, 1'b1, 1'b1);
      xb(crc, 1'b0, 1'b1);
      host_u.stop();
    end
    // single byte write to ram, read back by receive byte
    st(1'b0);
    xb(8'h40, 1'b0, 1'b0);
    xb(dat[5], 1'b0, 1'b0);
    host_u.stop();
    ptr(8'h40, 8'h00, 1'b0);
    st(1'b1);
    xb(dat[5], 1'b1, 1'b1);
    xb(crc, 1'b0, 1'b1);
    host_u.stop();
    // erase command without the enable must leave the page intact
    erase_enable = 1'b0;
    ptr(8'hf8, 8'h05, 1'b1);
    st(1'b0);
    xb(`SBTS_CMD_ERASE, 1'b0, 1'b0);
    host_u.stop();
    st(1'b1);
    xb(dat[0], 1'b1, 1'b1);
    xb(crc, 1'b0, 1'b1);
    host_u.stop();
    repeat (20) @(negedge core_clk);
    chk(9'(q.size()), 9'h000);
    stop_test();
  end
endmodule
